// ===== hdl/eest_pkg.sv
// Purpose: Shared constants and types for the ECC error status tracking block.
// Assumes: Word addresses of 25 bits; a half-page is eight 16-bit words (16 bytes).
// Notes: Bit positions and configuration bit indices live here so the logic never uses bare numbers.
package eest_pkg;

  // Address and word widths.
  localparam int ADDR_W = 25;
  localparam int WORD_W = 16;
  localparam int HP_LSB = 3;                  // First word-address bit above the half-page offset.
  localparam int HP_W = ADDR_W - HP_LSB;      // Half-page index width.
  localparam int LOW_SPLIT = 16;              // Lowest address bit held in the upper trap register.
  localparam int HIGH_W = ADDR_W - LOW_SPLIT; // Upper trap field width at the largest density.

  // Status word bit positions.
  localparam int ST_ECC_OFF = 0;
  localparam int ST_DATA_ERR = 1;
  localparam int ST_CODE_ERR = 2;
  localparam int ST_CORRECTED = 3;
  localparam int ST_DOUBLE = 4;

  // Configuration bit indices.
  localparam int PROT_TRAP_BOTH_BIT = 13;     // In protection_config_word: 1 traps single and double errors below 512 Mbit.
  localparam int VOL_STALL_OFF_BIT = 2;       // In volatile_config_word: 0 enables the strobe stall.

  // Density selections, in Mbit.
  localparam int DENS_128 = 128;
  localparam int DENS_256 = 256;
  localparam int DENS_512 = 512;

  // Upper trap register widths per density.
  localparam int HIGH_W_128 = 7;
  localparam int HIGH_W_256 = 8;
  localparam int HIGH_W_512 = 9;

  // Reset and saturation values.
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [WORD_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] STALL_CLK_MAX = 8'hFF;
  localparam logic [7:0] STALL_CLK_ONE = 8'h01;

  // Overlay-space commands as decoded by the command layer.
  typedef enum logic [2:0] {
    EEST_CMD_ENTER,
    EEST_CMD_EXIT,
    EEST_CMD_STATUS_READ,
    EEST_CMD_TRAP_LOW_READ,
    EEST_CMD_TRAP_HIGH_READ,
    EEST_CMD_COUNTER_READ,
    EEST_CMD_COUNTER_CLEAR
  } eest_cmd_t;

  // One decoded overlay command.
  typedef struct packed {
    eest_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
  } eest_request_t;

  // Result of one half-page ECC check from the decode datapath.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ecc_off;
    logic data_err;
    logic code_err;
    logic double_err;
    logic multi_prog;
  } eest_check_t;

endpackage : eest_pkg

// ===== hdl/eest_sync2.sv
// Purpose: Two flip-flop synchroniser for pin-level inputs.
// Assumes: Inputs are levels from outside the core clock domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module eest_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Metastability filter; reset value matches the idle pin level.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // eest_sync2
`default_nettype wire

// ===== hdl/eest_tracker.sv
// Purpose: ECC error status word, first-error address trap, error counter and read-strobe stall.
// Assumes: The ECC decode datapath and command decoder run on core_clk; CK and CS# arrive as pins.
// Notes: Reserved status bits are returned as zero, which the host must ignore anyway.
`timescale 1ns/100ps
`default_nettype none
module eest_tracker
  import eest_pkg::*;
#(
  parameter int DENSITY_MBIT = DENS_256
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ck_pin,
  input wire logic cs_n_pin,
  input wire logic req_valid,
  input wire eest_request_t req,
  input wire logic chk_valid,
  input wire eest_check_t chk,
  input wire logic other_overlay_active,
  input wire logic double_detect_en,
  input wire logic [WORD_W-1:0] protection_config_word,
  input wire logic [WORD_W-1:0] volatile_config_word,
  input wire logic strobe_src,
  input wire logic strobe_src_oe,
  output logic rd_valid,
  output logic [WORD_W-1:0] rd_data,
  output logic overlay_space,
  output logic rwds_out,
  output logic rwds_oe,
  output logic [7:0] stall_clocks
);

  typedef enum logic [1:0] {
    EEST_MODE_ARRAY,
    EEST_MODE_OVERLAY,
    EEST_MODE_STATUS_WAIT
  } eest_mode_t;

  // Density-derived shape of the trap and counter.
  localparam bit HAS_COUNTER = (DENSITY_MBIT != DENS_512);
  localparam int HIGH_USED = (DENSITY_MBIT == DENS_512) ? HIGH_W_512 :
                             (DENSITY_MBIT == DENS_256) ? HIGH_W_256 : HIGH_W_128;
  localparam logic [HIGH_W-1:0] HIGH_MASK = HIGH_W'((1 << HIGH_USED) - 1);

  // Builds a status word from its defined fields; reserved bits read as zero.
  function automatic logic [WORD_W-1:0] pack_status(input logic dbl, input logic corr,
                                                    input logic [2:0] unit);
    logic [WORD_W-1:0] w;
    w = WORD_ZERO;
    w[ST_DOUBLE] = dbl;
    w[ST_CORRECTED] = corr;
    w[ST_CODE_ERR] = unit[2];
    w[ST_DATA_ERR] = unit[1];
    w[ST_ECC_OFF] = unit[0];
    return w;
  endfunction

  // Pin synchronisers for the link clock and chip select.
  logic ck_s;
  logic cs_n_s;

  eest_sync2 #(
    .WIDTH(2),
    .INIT(2'h1)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({ck_pin, cs_n_pin}),
    .sync_out({ck_s, cs_n_s})
  );

  // State.
  eest_mode_t mode;
  logic ck_prev;
  logic sticky_corr;
  logic sticky_dbl;
  logic [2:0] unit_bits;
  logic trap_full;
  logic [HP_W-1:0] trap_hp;
  logic [WORD_W-1:0] err_count;
  logic burst_hp_valid;
  logic [HP_W-1:0] burst_hp;
  logic stall;

  // Edge and frame detection on the synchronised pins.
  wire ck_rise = ck_s & ~ck_prev;
  wire cs_active = ~cs_n_s;

  // Command decode.
  wire in_overlay = (mode != EEST_MODE_ARRAY);
  wire cmd_enter = req_valid & (req.cmd == EEST_CMD_ENTER) & ~in_overlay;
  wire cmd_exit = req_valid & (req.cmd == EEST_CMD_EXIT) & in_overlay;
  wire cmd_status = req_valid & (req.cmd == EEST_CMD_STATUS_READ) & in_overlay;
  wire cmd_trap_lo = req_valid & (req.cmd == EEST_CMD_TRAP_LOW_READ) & in_overlay;
  wire cmd_trap_hi = req_valid & (req.cmd == EEST_CMD_TRAP_HIGH_READ) & in_overlay;
  wire cmd_cnt_rd = req_valid & (req.cmd == EEST_CMD_COUNTER_READ) & in_overlay;
  wire cmd_cnt_clr = req_valid & (req.cmd == EEST_CMD_COUNTER_CLEAR) & in_overlay;

  // A reprogrammed half-page has no usable check code unless double detection is on.
  wire detect_live = chk_valid & ~(chk.multi_prog & ~double_detect_en);
  wire ev_double = detect_live & chk.double_err;
  wire ev_single = detect_live & ~chk.double_err & (chk.data_err | chk.code_err);
  wire [HP_W-1:0] chk_hp = chk.addr[ADDR_W-1:HP_LSB];

  // Trap type: double only at the largest density, else the config bit may add singles.
  wire trap_singles = HAS_COUNTER & protection_config_word[PROT_TRAP_BOTH_BIT];
  wire trap_hit = ev_double | (ev_single & trap_singles);
  wire trap_capture = trap_hit & ~trap_full;

  // Counting happens only for main-array reads, and a burst does not count the last counted half-page again.
  wire main_read = (mode == EEST_MODE_ARRAY) & ~other_overlay_active;
  wire hp_repeat = burst_hp_valid & (burst_hp == chk_hp);
  wire count_event = HAS_COUNTER & main_read & (ev_double | ev_single) & ~hp_repeat;
  wire count_step = count_event & (err_count != COUNT_MAX);

  // Sticky flags: exit clears, but an event in the same cycle wins.
  wire next_sticky_corr = (sticky_corr & ~cmd_exit) | ev_single;
  wire next_sticky_dbl = (sticky_dbl & ~cmd_exit) | ev_double;

  // Per-unit fields come from the check performed for the pending status read.
  wire unit_load = (mode == EEST_MODE_STATUS_WAIT) & chk_valid;
  wire [2:0] chk_unit = {chk.code_err, chk.data_err, chk.ecc_off};
  wire [2:0] next_unit_bits = unit_load ? chk_unit : (cmd_exit ? 3'h0 : unit_bits);

  // Trap register images, zero-filled above the density's top address bit.
  wire [WORD_W-1:0] trap_low_word = {trap_hp[LOW_SPLIT-HP_LSB-1:0], 3'h0};
  wire [HIGH_W-1:0] trap_high_bits = trap_hp[HP_W-1:LOW_SPLIT-HP_LSB] & HIGH_MASK;
  wire [WORD_W-1:0] trap_high_word = {{(WORD_W-HIGH_W){1'b0}}, trap_high_bits};

  // Stall holds while CS stays low; a fresh double error starts it when enabled.
  wire stall_enable = ~volatile_config_word[VOL_STALL_OFF_BIT];
  wire next_stall = cs_active & (stall | (ev_double & stall_enable));

  // Reply selection.
  wire reply_now = unit_load | cmd_trap_lo | cmd_trap_hi | cmd_cnt_rd;
  wire [WORD_W-1:0] status_word = pack_status(next_sticky_dbl, next_sticky_corr, chk_unit);
  wire [WORD_W-1:0] next_rd_data = unit_load ? status_word :
                                   cmd_trap_lo ? trap_low_word :
                                   cmd_trap_hi ? trap_high_word :
                                   cmd_cnt_rd ? err_count : WORD_ZERO;

  // Overlay mode machine; the status read waits for the addressed unit's check result.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode <= EEST_MODE_ARRAY;
    end else begin
      unique case (mode)
        EEST_MODE_ARRAY: begin
          if (cmd_enter) begin
            mode <= EEST_MODE_OVERLAY;
          end
        end
        EEST_MODE_OVERLAY: begin
          if (cmd_exit) begin
            mode <= EEST_MODE_ARRAY;
          end else if (cmd_status) begin
            mode <= EEST_MODE_STATUS_WAIT;
          end
        end
        EEST_MODE_STATUS_WAIT: begin
          if (cmd_exit) begin
            mode <= EEST_MODE_ARRAY;
          end else if (chk_valid) begin
            mode <= EEST_MODE_OVERLAY;
          end
        end
      endcase
    end
  end

  // Status word fields; hardware reset zeroes the whole word.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sticky_corr <= 1'b0;
      sticky_dbl <= 1'b0;
      unit_bits <= 3'h0;
    end else begin
      sticky_corr <= next_sticky_corr;
      sticky_dbl <= next_sticky_dbl;
      unit_bits <= next_unit_bits;
    end
  end

  // First-error trap. A capture in the exit cycle survives, so the event is not lost.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trap_full <= 1'b0;
      trap_hp <= '0;
    end else if (trap_capture) begin
      trap_full <= 1'b1;
      trap_hp <= chk_hp;
    end else if (cmd_exit) begin
      trap_full <= 1'b0;
      trap_hp <= '0;
    end
  end

  // Error counter: exit leaves it alone, only reset or the clear command zero it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err_count <= WORD_ZERO;
    end else if (cmd_cnt_clr) begin
      err_count <= WORD_ZERO;
    end else if (count_step) begin
      err_count <= err_count + COUNT_ONE;
    end
  end

  // Last counted half-page of the current burst; forgotten when CS rises so a new
  // transaction counts the same half-page again. Counting goes on during a stall.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      burst_hp_valid <= 1'b0;
      burst_hp <= '0;
    end else if (~cs_active) begin
      burst_hp_valid <= 1'b0;
    end else if (count_event) begin
      burst_hp_valid <= 1'b1;
      burst_hp <= chk_hp;
    end
  end

  // Strobe stall. The pin is still driven low while stalled so the host sees no edges.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stall <= 1'b0;
      rwds_out <= 1'b0;
      rwds_oe <= 1'b0;
    end else begin
      stall <= next_stall;
      rwds_out <= strobe_src & ~next_stall;
      rwds_oe <= strobe_src_oe | next_stall;
    end
  end

  // Link clocks seen while stalled; tells the read path the host kept clocking.
  // The host declares a bus error after a long silent strobe, so this saturates.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ck_prev <= 1'b1;
      stall_clocks <= 8'h00;
    end else begin
      ck_prev <= ck_s;
      if (~stall) begin
        stall_clocks <= 8'h00;
      end else if (ck_rise & (stall_clocks != STALL_CLK_MAX)) begin
        stall_clocks <= stall_clocks + STALL_CLK_ONE;
      end
    end
  end

  // Read replies, one-cycle valid pulse.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data <= WORD_ZERO;
      overlay_space <= 1'b0;
    end else begin
      rd_valid <= reply_now;
      rd_data <= next_rd_data;
      overlay_space <= (mode != EEST_MODE_ARRAY) ? ~cmd_exit : cmd_enter;
    end
  end

endmodule // eest_tracker
`default_nettype wire

// ===== test/eest_host_model.sv
// Purpose: Host controller side of the link: chip select, link clock and strobe watchdog.
// Assumes: The bench raises frame for each transaction.
// Notes: The link clock stands still between frames, as a real controller would leave it.
`timescale 1ns/100ps
`default_nettype none
module eest_host_model (
  input wire logic frame,
  input wire logic rwds_out,
  output logic ck_pin,
  output logic cs_n_pin,
  output logic bus_err
);
  int quiet = 0;
  assign cs_n_pin = ~frame;
  // The link clock is offset from the core clock so the two never share an edge.
  initial begin
    ck_pin = 1'b0;
    #7;
    forever begin
      #160;
      ck_pin = frame ? ~ck_pin : 1'b0;
    end
  end
  // Any strobe edge, or the end of a frame, restarts the silence count.
  always @(rwds_out or posedge cs_n_pin) begin
    quiet = 0;
  end
  always @(posedge ck_pin) begin
    quiet = quiet + 1;
  end
  assign bus_err = (quiet > 32);
endmodule // eest_host_model
`default_nettype wire

// ===== test/eest_tracker_chk.sv
// Purpose: Port-level assertions for eest_tracker.
// Assumes: One core_clk domain; rst asynchronous, active high.
// Notes: Pins pass a two-stage synchroniser, so pin conditions are held several cycles.
`timescale 1ns/100ps
`default_nettype none
module eest_tracker_chk
  import eest_pkg::*;
#(
  parameter int DENSITY_MBIT = DENS_256
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic req_valid,
  input wire eest_request_t req,
  input wire logic chk_valid,
  input wire eest_check_t chk,
  input wire logic [WORD_W-1:0] volatile_config_word,
  input wire logic strobe_src,
  input wire logic strobe_src_oe,
  input wire logic rd_valid,
  input wire logic [WORD_W-1:0] rd_data,
  input wire logic overlay_space,
  input wire logic rwds_out,
  input wire logic rwds_oe
);
  localparam int HW = (DENSITY_MBIT == DENS_128) ? HIGH_W_128 : (DENSITY_MBIT == DENS_256) ? HIGH_W_256 : HIGH_W_512;
  logic pend;
  wire logic take = req_valid && overlay_space;
  // Marks a status read that still waits for its unit's check result.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
    end else if (take && req.cmd == EEST_CMD_STATUS_READ) begin
      pend <= 1'b1;
    end else if (chk_valid || (take && req.cmd == EEST_CMD_EXIT)) begin
      pend <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_EXIT: assert property (take && req.cmd == EEST_CMD_EXIT |=> !overlay_space)
    else $error("overlay still entered after exit");
  AST_RESERVED: assert property (pend && chk_valid |=> rd_valid && rd_data[15:5] == 11'h000)
    else $error("reserved status bits not zero");
  AST_STATUS: assert property (pend && chk_valid && !chk.multi_prog |=> rd_valid
    && rd_data[ST_ECC_OFF] == $past(chk.ecc_off) && (rd_data[ST_DOUBLE] || !$past(chk.double_err)))
    else $error("status reply does not match the unit check");
  AST_CORR: assert property (pend && chk_valid && (chk.data_err || chk.code_err)
    && !chk.double_err && !chk.multi_prog |=> rd_valid && rd_data[ST_CORRECTED])
    else $error("correction flag missing after a corrected unit");
  AST_TRAPLO: assert property (take && req.cmd == EEST_CMD_TRAP_LOW_READ
    |=> rd_valid && rd_data[2:0] == 3'h0)
    else $error("low trap reply late or low bits set");
  AST_TRAPHI: assert property (take && req.cmd == EEST_CMD_TRAP_HIGH_READ
    |=> rd_valid && (rd_data >> HW) == 16'h0000)
    else $error("high trap reply late or unused bits set");
  AST_REFUSE: assert property (req_valid && !overlay_space && req.cmd inside {EEST_CMD_COUNTER_READ,
    EEST_CMD_TRAP_LOW_READ, EEST_CMD_TRAP_HIGH_READ, EEST_CMD_STATUS_READ} |=> !rd_valid)
    else $error("reply given outside the overlay");
  AST_STALL: assert property (!cs_n_pin [*3] ##0 (chk_valid && chk.double_err && !chk.multi_prog
    && !volatile_config_word[VOL_STALL_OFF_BIT]) |=> rwds_oe && !rwds_out)
    else $error("strobe not stalled after a double error");
  AST_FOLLOW: assert property (cs_n_pin [*5] |=> rwds_out == $past(strobe_src)
    && rwds_oe == $past(strobe_src_oe))
    else $error("strobe does not follow its source outside a frame");
endmodule // eest_tracker_chk
bind eest_tracker eest_tracker_chk #(.DENSITY_MBIT(DENSITY_MBIT)) u_chk (
  .core_clk(core_clk), .rst(rst), .cs_n_pin(cs_n_pin), .req_valid(req_valid), .req(req),
  .chk_valid(chk_valid), .chk(chk), .volatile_config_word(volatile_config_word), .strobe_src(strobe_src),
  .strobe_src_oe(strobe_src_oe), .rd_valid(rd_valid), .rd_data(rd_data), .overlay_space(overlay_space),
  .rwds_out(rwds_out), .rwds_oe(rwds_oe));
`default_nettype wire

// ===== test/eest_tracker_tb_top.sv
// Purpose: Self-checking bench for eest_tracker through decoded commands and check events.
// Assumes: Density 256, trapping of both error types, strobe stall enabled.
// Notes: Counter saturation is reached by one long run of back-to-back events outside any frame.
`timescale 1ns/100ps
`default_nettype none
module eest_tracker_tb_top
  import eest_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, chk_valid = 1'b0, frame = 1'b0;
  logic other_overlay_active = 1'b0, double_detect_en = 1'b1, strobe_src = 1'b0, strobe_src_oe = 1'b0;
  eest_request_t req = '0;
  eest_check_t chk = '0;
  logic [WORD_W-1:0] protection_config_word = 16'h2000, volatile_config_word = 16'h0000, rd_data;
  logic ck_pin, cs_n_pin, bus_err, rd_valid, overlay_space, rwds_out, rwds_oe;
  logic [7:0] stall_clocks;
  int miscompares = 0, n_checks = 0;
  localparam logic [ADDR_W-1:0] A1 = 25'h1A5B3C7, A2 = 25'h0001230, A3 = 25'h0004560;
  localparam logic [ADDR_W-1:0] A4 = 25'h0007890, A5 = 25'h000ABC0;
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // The read path toggles its strobe every cycle while a frame is open.
  always @(posedge core_clk) begin
    strobe_src <= frame & ~strobe_src;
    strobe_src_oe <= frame;
  end
  eest_host_model u_host (.frame(frame), .rwds_out(rwds_out), .ck_pin(ck_pin), .cs_n_pin(cs_n_pin), .bus_err(bus_err));
  eest_tracker #(.DENSITY_MBIT(DENS_256)) u_dut (.core_clk(core_clk), .rst(rst), .ck_pin(ck_pin),
    .cs_n_pin(cs_n_pin), .req_valid(req_valid), .req(req), .chk_valid(chk_valid), .chk(chk),
    .other_overlay_active(other_overlay_active), .double_detect_en(double_detect_en),
    .protection_config_word(protection_config_word), .volatile_config_word(volatile_config_word),
    .strobe_src(strobe_src), .strobe_src_oe(strobe_src_oe), .rd_valid(rd_valid), .rd_data(rd_data),
    .overlay_space(overlay_space), .rwds_out(rwds_out), .rwds_oe(rwds_oe), .stall_clocks(stall_clocks));
  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  // Each pulse task leaves an idle cycle so no strobe is lowered and raised in one step.
  task automatic cmd(eest_cmd_t c);
    @(posedge core_clk);
    req <= {c, {ADDR_W{1'b0}}};
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask
  task automatic ev(logic [ADDR_W-1:0] a, logic [4:0] f);
    @(posedge core_clk);
    chk <= {a, f};
    chk_valid <= 1'b1;
    @(posedge core_clk);
    chk_valid <= 1'b0;
  endtask
  task automatic rd(eest_cmd_t c, string nm, logic [15:0] exp, logic [4:0] f = 5'h00);
    int i;
    cmd(c);
    if (c == EEST_CMD_STATUS_READ) begin
      ev('0, f);
    end
    #1;
    for (i = 0; i < 20 && rd_valid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (rd_valid !== 1'b1) begin
      $display("[FAIL] %s expected a reply seen none", nm);
      miscompares++;
      stop_test();
    end else begin
      check(nm, rd_data, exp);
    end
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    cmd(EEST_CMD_ENTER);
    rd(EEST_CMD_STATUS_READ, "status_reset", 16'h0000);
    cmd(EEST_CMD_EXIT);
    // One array frame: stall, a repeated unit, a reprogrammed unit and another overlay.
    @(posedge core_clk);
    frame <= 1'b1;
    repeat (4) @(posedge core_clk);
    ev(A1, 5'h08);
    ev(A2, 5'h02);
    #1;
    check("stall", {14'h0000, rwds_oe, rwds_out}, 16'h0002);
    ev(A2, 5'h02);
    double_detect_en <= 1'b0;
    ev(A4, 5'h09);
    double_detect_en <= 1'b1;
    other_overlay_active <= 1'b1;
    ev(A5, 5'h08);
    other_overlay_active <= 1'b0;
    ev(A3, 5'h04);
    repeat (300) @(posedge core_clk);
    #1;
    check("bus_err", {15'h0000, bus_err}, 16'h0001);
    check("stall_clocks", {15'h0000, stall_clocks > 8'h20}, 16'h0001);
    @(posedge core_clk);
    frame <= 1'b0;
    repeat (4) @(posedge core_clk);
    cmd(EEST_CMD_ENTER);
    rd(EEST_CMD_COUNTER_READ, "count", 16'h0003);
    rd(EEST_CMD_TRAP_LOW_READ, "trap_low", {A1[15:3], 3'h0});
    rd(EEST_CMD_TRAP_HIGH_READ, "trap_high", {8'h00, A1[23:16]});
    rd(EEST_CMD_STATUS_READ, "sticky", 16'h0018);
    cmd(EEST_CMD_EXIT);
    cmd(EEST_CMD_ENTER);
    rd(EEST_CMD_TRAP_LOW_READ, "trap_clear", 16'h0000);
    rd(EEST_CMD_STATUS_READ, "status_exit", 16'h0000);
    rd(EEST_CMD_STATUS_READ, "unit_off", 16'h0001, 5'h10);
    rd(EEST_CMD_STATUS_READ, "unit_data", 16'h000A, 5'h08);
    rd(EEST_CMD_STATUS_READ, "unit_code", 16'h000C, 5'h04);
    rd(EEST_CMD_STATUS_READ, "unit_double", 16'h0018, 5'h02);
    rd(EEST_CMD_COUNTER_READ, "count_kept", 16'h0003);
    cmd(EEST_CMD_COUNTER_CLEAR);
    rd(EEST_CMD_COUNTER_READ, "count_clear", 16'h0000);
    cmd(EEST_CMD_EXIT);
    // Back-to-back singles outside any frame all count, so the counter must pin at its top value.
    @(posedge core_clk);
    chk <= {A5, 5'h08};
    chk_valid <= 1'b1;
    repeat (65537) @(posedge core_clk);
    chk_valid <= 1'b0;
    cmd(EEST_CMD_ENTER);
    rd(EEST_CMD_COUNTER_READ, "count_sat", COUNT_MAX);
    cmd(EEST_CMD_EXIT);
    cmd(EEST_CMD_COUNTER_READ);
    #1;
    check("refused", {15'h0000, rd_valid}, 16'h0000);
    stop_test();
  end
endmodule // eest_tracker_tb_top
`default_nettype wire
